// ### inc/afe_consts.svh
// Constants for the sampling and mode control block.
// Assumes inclusion by bare name from design files.
`ifndef AFE_CONSTS_SVH
`define AFE_CONSTS_SVH

// Register addresses
`define AFE_ADDR_AUTO_CYCLE_ENABLE_RESTART 8'h05

// Colour set codes
`define AFE_SET_RED           2'h0
`define AFE_SET_GREEN         2'h1
`define AFE_SET_BLUE          2'h2

// Input port codes
`define AFE_PORT_RED          2'h0
`define AFE_PORT_GREEN        2'h1
`define AFE_PORT_BLUE         2'h2

// Channel enable vectors, bit 0 red
`define AFE_CHAN_ALL          3'h7
`define AFE_CHAN_RG           3'h3
`define AFE_CHAN_NONE         3'h0

// Clock to strobe ratios
`define AFE_RATIO_3CH         8'h03
`define AFE_RATIO_2CH         8'h02
`define AFE_RATIO_WS_MIN      8'h06
`define AFE_RATIO_WS_MODE3    8'h03
`define AFE_RATIO_WS_HALF_RATIO_LINE_MODE    8'h02
`define AFE_PERIOD_MAX        8'hFF

// Strobe delay line depth
`define AFE_DLY_DEPTH         7
// Reference window shift depth
`define AFE_REF_DEPTH         4

`endif

// ### inc/afe_pkg.sv
// Types for the sampling and mode control block.
// Assumes nothing beyond a SystemVerilog compiler.
package afe_pkg;
    typedef enum logic [1:0] {
        AFE_COL_RED,
        AFE_COL_GREEN,
        AFE_COL_BLUE
    } afe_colour_t;
endpackage : afe_pkg

// ### inc/afe_strobe_if.sv
// Carrier between controller and video strobe detector.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface afe_strobe_if;
    logic       vid_lvl;
    logic       det_en;
    logic       edge_pol;
    logic [2:0] delay;
    logic       pulse;
    modport ctrl (output vid_lvl, output det_en, output edge_pol, output delay, input pulse);
    modport det  (input vid_lvl, input det_en, input edge_pol, input delay, output pulse);
endinterface : afe_strobe_if
`default_nettype wire

// ### hdl/afe_strobe_det.sv
// Video strobe edge detector and programmable delay.
// Assumes a synchronised strobe level on the interface.
`timescale 1ns/1ns
`default_nettype none
`include "afe_consts.svh"
module afe_strobe_det (
    input  wire logic clk_i,  // Conversion clock
    input  wire logic rst_i,  // Sync reset, high
    afe_strobe_if.det sif     // Strobe carrier
);
    logic                      prev_q;
    logic [`AFE_DLY_DEPTH-1:0] hist_q;
    logic                      pulse_q;
    wire                       rise_w = sif.vid_lvl & ~prev_q;
    wire                       fall_w = ~sif.vid_lvl & prev_q;
    // Without detection the falling edge marks the sample
    wire                       hit_w  = sif.det_en ? (sif.edge_pol ? rise_w : fall_w)
                                                   : fall_w;
    wire [2:0]                 idx_w  = 3'(sif.delay - 3'h1);
    wire                       pulse_d = (sif.delay == 3'h0) ? hit_w
                                                             : hist_q[idx_w];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q  <= 1'b0;
            hist_q  <= '0;
            pulse_q <= 1'b0;
        end else begin
            prev_q  <= sif.vid_lvl;
            hist_q  <= {hist_q[`AFE_DLY_DEPTH-2:0], hit_w};
            pulse_q <= pulse_d;
        end
    end

    assign sif.pulse = pulse_q;
endmodule : afe_strobe_det
`default_nettype wire

// ### hdl/afe_mode_ctrl.sv
// Sampling, clamp and colour set control of the front end.
// Assumes strobes and config bits arrive on the conversion clock.
`timescale 1ns/1ns
`default_nettype none
`include "afe_consts.svh"
// Functional notes
// - Line mode: red input, green/blue amplifiers off
// - Red channel uses selected colour set
// - Manual set select: 00 red, 01 green, 10 blue
// - Auto-cycle: reference pulse advances red, green, blue
// - Restart register write selects red set
// - Auto-cycle: clamp follows clamp style bit
// - Wide mode bit selects wide, zero normal
// - Normal ratios 3:1, 2:1, 1:1 by channel count; one-channel ratio is not checked
// - Single channel port select; invalid codes flagged
// - Wide mode: reference strobe is clamp control
// - Edge detect with chosen polarity makes pulse
// - Pulse delayed by three-bit cycle count
// - Wide mode takes video sample on internal pulse, same cycle
// - Strobes high connect video caps, and reference caps in normal mode with double sampling
// - Wide sub-modes: 2n:1, 3:1 or 2:1 ratios
// - Clamping only with level clamp enabled; style
// - Normal pixel clamp: switch follows reference strobe
// - Wide clamp needs double sampling, reference period
// - Normal mode: samples taken on strobe falling edges
// - Wide: reference high during video clamps sample
module afe_mode_ctrl (
    input  wire logic       clk_i,              // Conversion clock
    input  wire logic       rst_i,              // Sync reset, high
    input  wire logic       video_sample_strobe_i,     // Video level strobe
    input  wire logic       reference_sample_strobe_i, // Reference strobe
    input  wire logic       reg_wr_i,           // Register write strobe
    input  wire logic [7:0] reg_addr_i,         // Register write address
    input  wire logic       line_seq_mode_i,    // Line-sequential colour
    input  wire logic       auto_cycle_en_i,    // Auto-cycle enable
    input  wire logic [1:0] colour_set_sel_i,   // Manual colour set
    input  wire logic       clamp_style_i,      // 0 pixel, 1 line clamp
    input  wire logic       double_sampling_i,  // Double sampling on
    input  wire logic       wide_mode_i,        // Wide sample mode
    input  wire logic       edge_detect_en_i,   // Strobe edge detect
    input  wire logic       edge_polarity_i,    // 1 rising, 0 falling
    input  wire logic [2:0] strobe_delay_i,     // Pulse delay cycles
    input  wire logic       single_input_i,     // One-channel mode
    input  wire logic       dual_input_i,       // Two-channel mode
    input  wire logic [1:0] input_port_sel_i,   // One-channel port
    input  wire logic [1:0] ref_position_i,     // Wide reference position
    input  wire logic       half_ratio_i,       // Wide 2:1 line mode
    input  wire logic       level_clamp_en_i,   // Clamp enable
    output logic            wide_mode_o,        // Wide mode active
    output logic            green_blue_pd_o,    // Green/blue amps off
    output logic [1:0]      applied_set_o,      // Set on red channel
    output logic [2:0]      chan_en_o,          // Channel enables
    output logic            config_invalid_o,   // Illegal channel code
    output logic            config_conflict_o,  // Auto with double samp
    output logic            strobe_pulse_o,     // Internal strobe pulse
    output logic            video_cap_o,        // Video caps connected
    output logic            ref_cap_o,          // Reference caps on
    output logic            video_take_o,       // Video sample taken
    output logic            ref_take_o,         // Reference sample taken
    output logic            clamp_o,            // Clamp switch closed
    output logic            ratio_error_o,      // Strobe ratio wrong
    output logic            order_error_o       // Reference too early
);
    // Decode of channel enables shared by both modes
    function automatic logic [2:0] chan_dec(input logic s, input logic d,
                                            input logic [1:0] p, input logic l);
        logic [2:0] r;
        r = `AFE_CHAN_NONE;
        if (l) r = 3'h1;
        else if (s && !d && p != 2'h3) r = 3'(3'h1 << p);
        else if (d && !s) r = `AFE_CHAN_RG;
        else if (!s && !d) r = `AFE_CHAN_ALL;
        return r;
    endfunction : chan_dec

    logic vid_m_q, vid_s_q, vid_p_q;
    logic ref_m_q, ref_s_q, ref_p_q;
    afe_pkg::afe_colour_t ptr_q, ptr_d;
    logic [7:0] cnt_q;
    logic       arm_q, flag_q;
    logic [`AFE_REF_DEPTH-1:0] wsr_q;
    logic       wide_q, gbpd_q, inv_q, conf_q, pulse_q;
    logic [1:0] set_q;
    logic [2:0] chan_q;
    logic       vcap_q, rcap_q, vtake_q, rtake_q, clamp_q, rerr_q, oerr_q;

    afe_strobe_if sif ();
    assign sif.vid_lvl  = vid_s_q;
    assign sif.det_en   = edge_detect_en_i;
    assign sif.edge_pol = edge_polarity_i;
    assign sif.delay    = strobe_delay_i;

    afe_strobe_det u_det (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sif   (sif)
    );

    wire vid_rise_w = vid_s_q & ~vid_p_q;
    wire vid_fall_w = ~vid_s_q & vid_p_q;
    wire ref_rise_w = ref_s_q & ~ref_p_q;
    wire ref_fall_w = ~ref_s_q & ref_p_q;
    wire restart_w  = reg_wr_i && (reg_addr_i == `AFE_ADDR_AUTO_CYCLE_ENABLE_RESTART);
    wire auto_w     = auto_cycle_en_i & line_seq_mode_i;
    wire ws_take_w  = wide_mode_i & sif.pulse;
    wire ws_ref_w   = wsr_q[ref_position_i];

    // Auto-cycle pointer
    always_comb begin
        ptr_d = ptr_q;
        if (restart_w) begin
            ptr_d = afe_pkg::AFE_COL_RED;
        end else if (auto_cycle_en_i && ref_rise_w) begin
            unique case (ptr_q)
                afe_pkg::AFE_COL_RED:   ptr_d = afe_pkg::AFE_COL_GREEN;
                afe_pkg::AFE_COL_GREEN: ptr_d = afe_pkg::AFE_COL_BLUE;
                afe_pkg::AFE_COL_BLUE:  ptr_d = afe_pkg::AFE_COL_RED;
                default:                ptr_d = afe_pkg::AFE_COL_RED;
            endcase
        end
    end

    // Applied colour set; code 11 falls back to red
    wire [1:0] man_set_w = (colour_set_sel_i == 2'h3) ? `AFE_SET_RED
                                                      : colour_set_sel_i;
    wire [1:0] set_d     = !line_seq_mode_i ? `AFE_SET_RED
                         : auto_cycle_en_i  ? 2'(ptr_q) : man_set_w;

    // Clamp switch selection
    wire clamp_norm_w = clamp_style_i ? (ref_s_q & vid_s_q) : ref_s_q;
    wire clamp_ws_w   = double_sampling_i & flag_q & ws_ref_w;
    wire clamp_d      = !level_clamp_en_i ? 1'b0
                      : auto_w            ? clamp_style_i
                      : wide_mode_i       ? clamp_ws_w : clamp_norm_w;

    // Reference capacitors: pin in normal mode, window in wide mode
    wire rcap_d  = double_sampling_i & (wide_mode_i ? ws_ref_w : ref_s_q);
    wire vtake_d = wide_mode_i ? ws_take_w : vid_fall_w;
    wire rtake_d = double_sampling_i & ~auto_w
                 & (wide_mode_i ? ws_ref_w : ref_fall_w);

    // Expected clock periods per strobe period
    wire ws_m3_w = single_input_i & double_sampling_i & (ref_position_i == 2'h0);
    wire [7:0] per_w = cnt_q;
    wire ratio_ok_w = wide_mode_i ?
                      (half_ratio_i ? per_w == `AFE_RATIO_WS_HALF_RATIO_LINE_MODE
                       : ws_m3_w ? per_w == `AFE_RATIO_WS_MODE3
                       : (per_w >= `AFE_RATIO_WS_MIN) && !per_w[0])
                    : (dual_input_i ? per_w == `AFE_RATIO_2CH
                       : single_input_i ? 1'b1
                       : per_w == `AFE_RATIO_3CH);

    // Synchronisers and edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vid_m_q <= 1'b0;
            vid_s_q <= 1'b0;
            vid_p_q <= 1'b0;
            ref_m_q <= 1'b0;
            ref_s_q <= 1'b0;
            ref_p_q <= 1'b0;
        end else begin
            vid_m_q <= video_sample_strobe_i;
            vid_s_q <= vid_m_q;
            vid_p_q <= vid_s_q;
            ref_m_q <= reference_sample_strobe_i;
            ref_s_q <= ref_m_q;
            ref_p_q <= ref_s_q;
        end
    end

    // Pointer, wide mode sample state, period counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_q <= afe_pkg::AFE_COL_RED;
            arm_q <= 1'b0;
            flag_q <= 1'b0;
            wsr_q <= '0;
            cnt_q <= 8'h00;
        end else begin
            ptr_q <= ptr_d;
            if (vid_s_q) arm_q <= ref_s_q;
            if (ws_take_w) flag_q <= arm_q;
            wsr_q <= {wsr_q[`AFE_REF_DEPTH-2:0], ws_take_w};
            if (vid_rise_w) cnt_q <= 8'h01;
            else if (cnt_q != 8'h00 && cnt_q != `AFE_PERIOD_MAX) cnt_q <= 8'(cnt_q + 8'h01);
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_q  <= 1'b0;
            gbpd_q  <= 1'b0;
            set_q   <= `AFE_SET_RED;
            chan_q  <= `AFE_CHAN_NONE;
            inv_q   <= 1'b0;
            conf_q  <= 1'b0;
            pulse_q <= 1'b0;
            vcap_q  <= 1'b0;
            rcap_q  <= 1'b0;
            vtake_q <= 1'b0;
            rtake_q <= 1'b0;
            clamp_q <= 1'b0;
            rerr_q  <= 1'b0;
            oerr_q  <= 1'b0;
        end else begin
            wide_q  <= wide_mode_i;
            gbpd_q  <= line_seq_mode_i;
            set_q   <= set_d;
            chan_q  <= chan_dec(single_input_i, dual_input_i, input_port_sel_i,
                                line_seq_mode_i);
            inv_q   <= (single_input_i & dual_input_i)
                     | (single_input_i & (input_port_sel_i == 2'h3));
            conf_q  <= auto_cycle_en_i & double_sampling_i;
            pulse_q <= sif.pulse;
            vcap_q  <= vid_s_q;
            rcap_q  <= rcap_d;
            vtake_q <= vtake_d;
            rtake_q <= rtake_d;
            clamp_q <= clamp_d;
            if (vid_rise_w && cnt_q != 8'h00) rerr_q <= ~ratio_ok_w;
            oerr_q  <= ~wide_mode_i & ~auto_w & ref_rise_w & vid_s_q;
        end
    end

    assign wide_mode_o       = wide_q;
    assign green_blue_pd_o   = gbpd_q;
    assign applied_set_o     = set_q;
    assign chan_en_o         = chan_q;
    assign config_invalid_o  = inv_q;
    assign config_conflict_o = conf_q;
    assign strobe_pulse_o    = pulse_q;
    assign video_cap_o       = vcap_q;
    assign ref_cap_o         = rcap_q;
    assign video_take_o      = vtake_q;
    assign ref_take_o        = rtake_q;
    assign clamp_o           = clamp_q;
    assign ratio_error_o     = rerr_q;
    assign order_error_o     = oerr_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_gb_pd;
        line_seq_mode_i |=> green_blue_pd_o && chan_en_o == 3'h1;
    endproperty
    a_gb_pd: assert property (p_gb_pd) else $error("line mode amps not off");

    property p_manual_set;
        (line_seq_mode_i && !auto_cycle_en_i && colour_set_sel_i != 2'h3)
            |=> applied_set_o == $past(colour_set_sel_i);
    endproperty
    a_manual_set: assert property (p_manual_set) else $error("manual set wrong");

    property p_auto_adv;
        (auto_cycle_en_i && ref_rise_w && !restart_w) |=> ptr_q != $past(ptr_q);
    endproperty
    a_auto_adv: assert property (p_auto_adv) else $error("auto-cycle stuck");

    property p_restart;
        restart_w |=> ptr_q == afe_pkg::AFE_COL_RED ##1
                      (!line_seq_mode_i || !auto_cycle_en_i ||
                       applied_set_o == `AFE_SET_RED || $past(ref_rise_w));
    endproperty
    a_restart: assert property (p_restart) else $error("restart missed");

    property p_once;
        ref_s_q [*3] |-> ##1 $stable(ptr_q) || $past(restart_w);
    endproperty
    a_once: assert property (p_once) else $error("pointer advanced twice");

    property p_auto_clamp;
        (auto_w && level_clamp_en_i) |=> clamp_o == $past(clamp_style_i);
    endproperty
    a_auto_clamp: assert property (p_auto_clamp) else $error("auto clamp wrong");

    property p_no_clamp;
        !level_clamp_en_i |=> !clamp_o;
    endproperty
    a_no_clamp: assert property (p_no_clamp) else $error("clamp while disabled");

    property p_pix_clamp;
        (!wide_mode_i && !auto_w && level_clamp_en_i && !clamp_style_i)
            |=> clamp_o == $past(ref_s_q);
    endproperty
    a_pix_clamp: assert property (p_pix_clamp) else $error("pixel clamp wrong");

    property p_ws_nods;
        (wide_mode_i && !double_sampling_i && !auto_w) |=> !clamp_o;
    endproperty
    a_ws_nods: assert property (p_ws_nods) else $error("wide clamp without ds");

    property p_ws_take;
        (wide_mode_i && sif.pulse) |=> video_take_o && strobe_pulse_o;
    endproperty
    a_ws_take: assert property (p_ws_take) else $error("wide sample missed");

    property p_nm_take;
        (!wide_mode_i && vid_fall_w) |=> video_take_o;
    endproperty
    a_nm_take: assert property (p_nm_take) else $error("video sample missed");

    property p_invalid;
        (single_input_i && dual_input_i && !line_seq_mode_i)
            |=> config_invalid_o && chan_en_o == 3'h0;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid code accepted");

    property p_delay0;
        (edge_detect_en_i && edge_polarity_i && strobe_delay_i == 3'h0
         && $stable(strobe_delay_i) && vid_rise_w) |-> ##2 strobe_pulse_o;
    endproperty
    a_delay0: assert property (p_delay0) else $error("strobe pulse late");

    property p_ref_take;
        (!wide_mode_i && double_sampling_i && !auto_w && ref_fall_w) |=> ref_take_o;
    endproperty
    a_ref_take: assert property (p_ref_take) else $error("reference sample missed");

    property p_ws_clamp;
        (wide_mode_i && double_sampling_i && !auto_w && level_clamp_en_i && ws_ref_w)
            |=> clamp_o == $past(flag_q);
    endproperty
    a_ws_clamp: assert property (p_ws_clamp) else $error("wide clamp not per sample");

    property p_rcap_nods;
        !double_sampling_i |=> !ref_cap_o;
    endproperty
    a_rcap_nods: assert property (p_rcap_nods) else $error("reference caps without ds");

    property p_ratio3;
        (!wide_mode_i && !single_input_i && !dual_input_i && vid_rise_w
         && cnt_q == `AFE_RATIO_3CH) |=> !ratio_error_o;
    endproperty
    a_ratio3: assert property (p_ratio3) else $error("good 3:1 ratio flagged");

    c_wrap:  cover property (ptr_q == afe_pkg::AFE_COL_BLUE ##1 ptr_q == afe_pkg::AFE_COL_RED);
    c_ws:    cover property (wide_mode_i && video_take_o ##[1:4] ref_take_o);
    c_wsclp: cover property (wide_mode_i && clamp_o);
    c_ratio: cover property (ratio_error_o);
endmodule : afe_mode_ctrl
`default_nettype wire

// ### tb/afe_scan_ctl.sv
// Scanner timing controller model that drives the two sampling strobes.
// Assumes the conversion clock and reset of the block under test.
`timescale 1ns/1ns
`default_nettype none
module afe_scan_ctl (
    input  wire logic       clk_i,      // Conversion clock
    input  wire logic       rst_i,      // Sync reset, high
    input  wire logic       run_i,      // Start frames while high
    input  wire logic [3:0] period_i,   // Clocks per video strobe
    input  wire logic [1:0] ref_mode_i, // 0 off, 1 after, 2 overlap, 3 held
    output logic            vid_o,      // Video sample strobe
    output logic            ref_o       // Reference sample strobe
);
    logic [3:0] ph_q;
    wire        start = run_i && ph_q == 4'h0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_q  <= 4'h0;
            vid_o <= 1'b0;
            ref_o <= 1'b0;
        end else begin
            // Strobe spacing sets the clock ratio
            if (start || ph_q != 4'h0)
                ph_q <= (ph_q == period_i - 4'h1) ? 4'h0 : ph_q + 4'h1;
            // Video falls on a rising edge, ahead of the next one
            vid_o <= start;
            // In mode 1 the reference rises a full cycle after video falls
            ref_o <= (ref_mode_i == 2'h1 && ph_q == 4'h2) || (ref_mode_i == 2'h2 && start)
                     || ref_mode_i == 2'h3;
        end
    end
endmodule : afe_scan_ctl
`default_nettype wire

// ### tb/test_afe_mode_ctrl.sv
// Self-checking bench for the sampling and mode control block.
// Assumes the design files, the constants header and the strobe model.
`timescale 1ns/1ns
`default_nettype none
`include "afe_consts.svh"
module test_afe_mode_ctrl;
    logic       clk_i, rst_i, reg_wr, run, line_seq, auto_en, style, ds, wide;
    logic       det_en, pol, single, dual, half, lce, vid, ref_s, wmode, gbpd;
    logic       invalid, conflict, pulse, vcap, rcap, vtake, rtake, clamp, rerr, oerr;
    logic [7:0] reg_addr;
    logic [1:0] set_sel, port, ref_pos, ref_mode, aset;
    logic [2:0] delay, chan;
    logic [3:0] period;
    logic [5:0] seen;
    int         n_mismatch, check_count;

    afe_mode_ctrl dut (
        .clk_i(clk_i), .rst_i(rst_i), .video_sample_strobe_i(vid),
        .reference_sample_strobe_i(ref_s), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr),
        .line_seq_mode_i(line_seq), .auto_cycle_en_i(auto_en), .colour_set_sel_i(set_sel),
        .clamp_style_i(style), .double_sampling_i(ds), .wide_mode_i(wide),
        .edge_detect_en_i(det_en), .edge_polarity_i(pol), .strobe_delay_i(delay),
        .single_input_i(single), .dual_input_i(dual), .input_port_sel_i(port),
        .ref_position_i(ref_pos), .half_ratio_i(half), .level_clamp_en_i(lce),
        .wide_mode_o(wmode), .green_blue_pd_o(gbpd), .applied_set_o(aset),
        .chan_en_o(chan), .config_invalid_o(invalid), .config_conflict_o(conflict),
        .strobe_pulse_o(pulse), .video_cap_o(vcap), .ref_cap_o(rcap),
        .video_take_o(vtake), .ref_take_o(rtake), .clamp_o(clamp),
        .ratio_error_o(rerr), .order_error_o(oerr)
    );
    afe_scan_ctl ctl (
        .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .period_i(period),
        .ref_mode_i(ref_mode), .vid_o(vid), .ref_o(ref_s)
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a);
        @(posedge clk_i);
        reg_wr   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_i);
        reg_wr   <= 1'b0;
        tick(3);
    endtask : wr

    task automatic shot;
        @(posedge clk_i);
        run <= 1'b1;
        @(posedge clk_i);
        run <= 1'b0;
        tick(12);
    endtask : shot

    task automatic watch(input int n);
        seen = 6'h00;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            seen |= {oerr, clamp, rtake, vtake, rcap, vcap};
        end
    endtask : watch

    task automatic lat(input logic de, input logic p, input logic [2:0] d, output int n);
        @(posedge clk_i);
        det_en <= de;
        pol    <= p;
        delay  <= d;
        tick(4);
        @(posedge clk_i);
        run <= 1'b1;
        @(posedge clk_i);
        run <= 1'b0;
        for (n = 0; n < 40 && pulse !== 1'b1; n++)
            tick(1);
        check("take_with_pulse", {7'h00, vtake}, 8'h01);
        if (n == 40) begin
            n_mismatch++;
            print_verdict;
        end
        tick(20);
    endtask : lat

    task automatic t_reset;
        @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check("reset_a", {wmode, gbpd, invalid, conflict, pulse, vcap, rcap, vtake}, 8'h00);
        check("reset_b", {aset, chan, clamp, rtake, rerr}, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_config;
        logic [7:0] tab [7] = '{8'h07, 8'h43, 8'h81, 8'h92, 8'hA4, 8'hB8, 8'hC8};
        foreach (tab[i]) begin
            @(posedge clk_i);
            single <= tab[i][7];
            dual   <= tab[i][6];
            port   <= tab[i][5:4];
            tick(2);
            check("chan_cfg", {4'h0, invalid, chan}, {4'h0, tab[i][3:0]});
        end
        @(posedge clk_i);
        {single, dual, wide, auto_en, ds} <= 5'h07;
        tick(2);
        check("wide_conflict", {6'h00, wmode, conflict}, 8'h03);
        @(posedge clk_i);
        {wide, auto_en, ds} <= 3'h0;
        tick(2);
        check("normal_mode", {7'h00, wmode}, 8'h00);
        $display("test config done");
    endtask : t_config

    task automatic t_manual;
        @(posedge clk_i);
        line_seq <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            set_sel <= 2'(s);
            tick(3);
            check("manual_set", {6'h00, aset}, (s == 3) ? 8'h00 : 8'(s));
        end
        check("line_mode", {4'h0, gbpd, chan}, 8'h09);
        $display("test manual done");
    endtask : t_manual

    task automatic t_auto;
        @(posedge clk_i);
        auto_en  <= 1'b1;
        ds       <= 1'b0;
        ref_mode <= 2'h1;
        wr(`AFE_ADDR_AUTO_CYCLE_ENABLE_RESTART);
        check("restart_a", {6'h00, aset}, 8'h00);
        for (int i = 1; i < 5; i++) begin
            shot;
            check("auto_step", {6'h00, aset}, 8'(i % 3));
        end
        wr(8'h04);
        check("other_addr", {6'h00, aset}, 8'h01);
        wr(`AFE_ADDR_AUTO_CYCLE_ENABLE_RESTART);
        check("restart_b", {6'h00, aset}, 8'h00);
        @(posedge clk_i);
        ref_mode <= 2'h3;
        tick(12);
        check("held_ref", {6'h00, aset}, 8'h01);
        @(posedge clk_i);
        ref_mode <= 2'h1;
        run      <= 1'b1;
        watch(24);
        check("auto_clamp_off", {7'h00, seen[4]}, 8'h00);
        @(posedge clk_i);
        style <= 1'b1;
        tick(4);
        watch(24);
        check("auto_clamp_on", {7'h00, seen[4]}, 8'h01);
        @(posedge clk_i);
        lce <= 1'b0;
        tick(4);
        watch(24);
        check("clamp_gated", {7'h00, seen[4]}, 8'h00);
        @(posedge clk_i);
        {run, auto_en, line_seq, style, lce} <= 5'h01;
        $display("test auto done");
    endtask : t_auto

    task automatic t_clamp;
        logic [11:0] tab [8] = '{12'h65F, 12'h255, 12'h44F, 12'h74F,
                                 12'h7BF, 12'hE9F, 12'hE0F, 12'hA85};
        foreach (tab[i]) begin
            @(posedge clk_i);
            {wide, ds, lce, style} <= tab[i][11:8];
            ref_mode <= tab[i][7:6];
            run      <= 1'b1;
            tick(12);
            watch(24);
            check("strobe_outs", {2'h0, seen}, {2'h0, tab[i][5:0]});
        end
        @(posedge clk_i);
        {run, wide, ds, lce, style} <= 5'h02;
        ref_mode <= 2'h0;
        $display("test clamp done");
    endtask : t_clamp

    task automatic t_ratio;
        logic [15:0] tab [11] = '{16'h0003, 16'h0104, 16'h2002, 16'h2103, 16'h4005,
                                  16'h8006, 16'h8107, 16'h8104, 16'h9002,
                                  16'hC013, 16'hC103};
        foreach (tab[i]) begin
            @(posedge clk_i);
            {wide, single, dual, half} <= tab[i][15:12];
            ds     <= tab[i][4];
            period <= tab[i][3:0];
            run    <= 1'b1;
            tick(40);
            check("ratio", {7'h00, rerr}, {7'h00, tab[i][8]});
        end
        @(posedge clk_i);
        {run, wide, single, dual, half, ds} <= 6'h00;
        period <= 4'h6;
        $display("test ratio done");
    endtask : t_ratio

    task automatic t_edge;
        int a, b, c, e;
        @(posedge clk_i);
        wide <= 1'b1;
        lat(1'b1, 1'b1, 3'h0, a);
        lat(1'b1, 1'b1, 3'h7, b);
        lat(1'b1, 1'b0, 3'h0, c);
        lat(1'b0, 1'b1, 3'h0, e);
        check("delay_span", 8'(b - a), 8'h07);
        check("fall_vs_rise", 8'(c - a), 8'h01);
        check("detect_off", 8'(e - c), 8'h00);
        $display("test edge done");
    endtask : t_edge

    initial begin
        rst_i = 1'b1;
        {reg_wr, run, line_seq, auto_en, style, ds, wide, det_en, pol} = 9'h000;
        {single, dual, half} = 3'h0;
        lce      = 1'b1;
        reg_addr = 8'h00;
        {set_sel, port, ref_pos, ref_mode} = 8'h00;
        delay    = 3'h0;
        period   = 4'h6;
        repeat (11) @(posedge clk_i);
        t_reset;
        t_config;
        t_manual;
        t_auto;
        t_clamp;
        t_ratio;
        t_edge;
        print_verdict;
    end
endmodule : test_afe_mode_ctrl
`default_nettype wire
